// file: sram_dev_model.sv
// Behavioural model of the 512K x 8 asynchronous SRAM
`timescale 1ns/1ps
module sram_dev_model
  import sram_pkg::*;
#(
  parameter int ACC_NS = 70 // Access time, slowest legal answer
)(
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic cs_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [DATA_W-1:0] host_d_i,
  input wire logic host_oe_n_i,
  output logic [DATA_W-1:0] bus_o // Resolved level of the data pins
);
  logic [DATA_W-1:0] mem [bit [ADDR_W-1:0]];
  realtime t_acc = 0.0;
  realtime t_sel = 0.0;
  realtime t_oe = 0.0;
  bit wr_on = 1'b0;
  initial bus_o = 8'h5A;
  always @(addr_i, cs_n_i) t_acc = $realtime;
  always @(negedge cs_n_i) t_sel = $realtime;
  always @(negedge oe_n_i, posedge we_n_i) t_oe = $realtime;
  // decode, no pull: lines toggle when undriven
  always #1 begin
    if (!host_oe_n_i) bus_o = host_d_i;
    else if (!cs_n_i && !oe_n_i && we_n_i && $realtime - t_sel >= 10 && $realtime - t_oe >= 5) begin
      // valid after access, old data held 10 ns
      if ($realtime - t_acc >= ACC_NS && $realtime - t_oe >= OE_ACCESS_MAX_NS)
        bus_o = mem.exists(addr_i) ? mem[addr_i] : ~addr_i[7:0];
      else if ($realtime - t_acc >= 10) bus_o = ~bus_o;
    end else bus_o = ~bus_o;
  end
  // store at end of select and write overlap
  always @(cs_n_i, we_n_i) begin
    if (!cs_n_i && !we_n_i) wr_on = 1'b1;
    else if (wr_on) begin
      mem[addr_i] = bus_o;
      wr_on = 1'b0;
    end
  end
endmodule // sram_dev_model

// file: sram_host.sv
// Host-side controller driving an asynchronous 512K x 8 SRAM
//
// Behaviour
// - Write overlap at least 50 ns
// - Address set with write start, 60 ns before end
// - Select active 60 ns before write end
// - Address held to write end, cycle 70 ns
// - Data valid 30 ns before end, held through
// - Writes hold OE high; pulse still covers write-to-float
// - Host never fights device-driven bus
// - Select inactive before retention, recover one read cycle
`timescale 1ns/1ps

module sram_host
  import sram_pkg::*;
(
  input wire logic core_clk_i, // Core clock, 200 MHz
  input wire logic rstn_i, // Asynchronous reset, active low
  input wire logic req_valid_i, // Access request
  input wire logic req_write_i, // 1 write, 0 read
  input wire logic [ADDR_W-1:0] req_addr_i, // Word address
  input wire logic [DATA_W-1:0] req_wdata_i, // Write byte
  output logic req_ready_o, // Request taken when high with valid
  output logic rsp_valid_o, // Read data pulse
  output logic [DATA_W-1:0] rsp_rdata_o, // Read byte
  input wire logic retain_req_i, // Level: enter data retention
  output logic retain_o, // High while in retention
  output logic [ADDR_W-1:0] addr_bus_o, // Address pins
  input wire logic [DATA_W-1:0] data_bus_i, // Data pins, sampled
  output logic [DATA_W-1:0] data_bus_o, // Data pins, driven
  output logic data_bus_oe_n_o, // Low while host drives data
  output logic cs_n_o, // Select, active low
  output logic oe_n_o, // Output enable, active low
  output logic we_n_o // Write enable, active low
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sram_state_t state_q, state_d; // Controller state
  logic [CNT_W-1:0] cnt_q, cnt_d; // Cycle counter within a phase
  logic [ADDR_W-1:0] addr_q, addr_d; // Address pins register
  logic [DATA_W-1:0] wdata_q, wdata_d; // Write data register
  logic [DATA_W-1:0] rdata_q, rdata_d; // Captured read data
  logic rsp_q, rsp_d; // Read response pulse
  logic cs_n_q, cs_n_d; // Select pin register
  logic oe_n_q, oe_n_d; // Output enable pin register
  logic we_n_q, we_n_d; // Write enable pin register
  logic drv_n_q, drv_n_d; // Data driver enable, low drives

  // Accept new work only from idle with no retention pending
  assign req_ready_o = (state_q == SR_IDLE) && !retain_req_i;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    rsp_d = 1'b0;
    cs_n_d = cs_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    drv_n_d = drv_n_q;
    case (state_q)
      // Idle: output disable, bus floats on both sides
      SR_IDLE: begin
        if (retain_req_i) begin
          cs_n_d = 1'b1;
          oe_n_d = 1'b1;
          state_d = SR_RETAIN;
        end else if (req_valid_i) begin
          addr_d = req_addr_i;
          cnt_d = '0;
          cs_n_d = 1'b0;
          if (req_write_i) begin
            wdata_d = req_wdata_i;
            we_n_d = 1'b0;
            oe_n_d = 1'b1;
            state_d = SR_WRITE;
          end else begin
            oe_n_d = 1'b0;
            state_d = SR_READ;
          end
        end
      end
      // Read: wait past access times, then sample
      SR_READ: begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q == CNT_W'(READ_CYC - 1)) begin
          rdata_d = data_bus_i;
          rsp_d = 1'b1;
          oe_n_d = 1'b1;
          cs_n_d = 1'b1;
          cnt_d = '0;
          state_d = SR_FLOAT;
        end
      end
      // Bus float: device releases before anything else starts
      SR_FLOAT: begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q == CNT_W'(FLOAT_CYC - 1)) begin
          state_d = SR_IDLE;
        end
      end
      // Write pulse: select and write low together
      SR_WRITE: begin
        cnt_d = cnt_q + 8'h01;
        drv_n_d = 1'b0;
        if (cnt_q == CNT_W'(WP_CYC - 1)) begin
          we_n_d = 1'b1;
          cs_n_d = 1'b1;
          state_d = SR_WREC;
        end
      end
      // Recovery: hold address and data past the end
      SR_WREC: begin
        cnt_d = cnt_q + 8'h01;
        drv_n_d = 1'b1;
        if (cnt_q >= CNT_W'(WC_CYC - 1)) begin
          state_d = SR_IDLE;
        end
      end
      // Retention: select held off, other pins idle
      SR_RETAIN: begin
        cnt_d = '0;
        if (!retain_req_i) begin
          state_d = SR_RECOVER;
        end
      end
      // Recovery from retention: one read cycle time
      SR_RECOVER: begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q == CNT_W'(RECOV_CYC - 1)) begin
          state_d = SR_IDLE;
        end
      end
      default: begin
        state_d = SR_IDLE;
        cs_n_d = 1'b1;
        oe_n_d = 1'b1;
        we_n_d = 1'b1;
        drv_n_d = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= SR_IDLE;
      cnt_q <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      rsp_q <= 1'b0;
      cs_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      drv_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      rsp_q <= rsp_d;
      cs_n_q <= cs_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      drv_n_q <= drv_n_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops except ready (decoded from state and retain_req_i) and retain (decoded from state)
  // ----------------------------------------------------------------
  assign addr_bus_o = addr_q;
  assign data_bus_o = wdata_q;
  assign data_bus_oe_n_o = drv_n_q;
  assign cs_n_o = cs_n_q;
  assign oe_n_o = oe_n_q;
  assign we_n_o = we_n_q;
  assign rsp_valid_o = rsp_q;
  assign rsp_rdata_o = rdata_q;
  assign retain_o = (state_q == SR_RETAIN);

endmodule // sram_host

// file: sram_host_checker.sv
// Pin timing checker for the SRAM host controller
`timescale 1ns/1ps
module sram_host_checker
  import sram_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic retain_o,
  input wire logic [ADDR_W-1:0] addr_bus_o,
  input wire logic [DATA_W-1:0] data_bus_o,
  input wire logic data_bus_oe_n_o,
  input wire logic cs_n_o,
  input wire logic oe_n_o,
  input wire logic we_n_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // Write overlap and its end
  sequence s_wr_on; !we_n_o && !cs_n_o; endsequence
  sequence s_wr_end; $rose(we_n_o); endsequence
  a_wr_overlap_len: assert property ($fell(we_n_o) |-> s_wr_on [*8] ##1 s_wr_on [*2])
    else $error("write overlap too short");
  a_addr_wr_stable: assert property ($past(!we_n_o) |-> $stable(addr_bus_o))
    else $error("address moved during write");
  a_sel_before_end: assert property (s_wr_end |-> $past(!cs_n_o, 12))
    else $error("select late before write end");
  a_data_setup_hold: assert property (s_wr_end |-> !data_bus_oe_n_o && $past(!data_bus_oe_n_o, 6))
    else $error("write data setup or hold short");
  a_no_bus_fight: assert property (!oe_n_o |-> data_bus_oe_n_o)
    else $error("host drives while device may drive");
  a_float_wait: assert property ($rose(oe_n_o) |-> data_bus_oe_n_o [*6])
    else $error("host drove before bus floated");
  a_wr_oe_off: assert property (!we_n_o |-> oe_n_o)
    else $error("output enable low in write");
  a_cycle_min: assert property ($fell(cs_n_o) |-> !req_ready_o [*8] ##1 !req_ready_o [*6])
    else $error("cycle shorter than 70 ns");
  a_retain_desel: assert property (retain_o |-> cs_n_o)
    else $error("select active in retention");
  a_recover_wait: assert property ($fell(retain_o) |-> cs_n_o [*8] ##1 cs_n_o [*6])
    else $error("access before recovery time");
  a_read_sample: assert property ($fell(oe_n_o) |-> ##15 rsp_valid_o)
    else $error("read data taken at wrong time");
endmodule // sram_host_checker
bind sram_host sram_host_checker i_sram_host_checker (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .retain_o(retain_o), .addr_bus_o(addr_bus_o),
  .data_bus_o(data_bus_o), .data_bus_oe_n_o(data_bus_oe_n_o), .cs_n_o(cs_n_o), .oe_n_o(oe_n_o),
  .we_n_o(we_n_o));

// file: sram_host_tb_top.sv
// Testbench for the SRAM host controller against a device model
`timescale 1ns/1ps
module sram_host_tb_top;
  import sram_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = 19'h00000;
  logic [DATA_W-1:0] req_wdata = 8'h00;
  logic retain_req = 1'b0;
  logic req_ready, rsp_valid, retain, data_oe_n, cs_n, oe_n, we_n;
  logic [DATA_W-1:0] rsp_rdata, bus_out, bus_lvl;
  logic [ADDR_W-1:0] pin_addr;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  initial forever #2.5 core_clk = ~core_clk;
  sram_host i_sram_host (.core_clk_i(core_clk), .rstn_i(rstn), .req_valid_i(req_valid), .req_write_i(req_write),
    .req_addr_i(req_addr), .req_wdata_i(req_wdata), .req_ready_o(req_ready), .rsp_valid_o(rsp_valid),
    .rsp_rdata_o(rsp_rdata), .retain_req_i(retain_req), .retain_o(retain), .addr_bus_o(pin_addr),
    .data_bus_i(bus_lvl), .data_bus_o(bus_out), .data_bus_oe_n_o(data_oe_n), .cs_n_o(cs_n), .oe_n_o(oe_n),
    .we_n_o(we_n));
  sram_dev_model i_sram_dev_model (.addr_i(pin_addr), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .host_d_i(bus_out), .host_oe_n_i(data_oe_n), .bus_o(bus_lvl));
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      results();
    end
  end
  task results();
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Hold request until taken, release after
  // A request that is never taken is caught by the hang guard
  task req(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge core_clk);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(posedge core_clk);
    while (req_ready !== 1'b1) @(posedge core_clk);
    @(negedge core_clk);
    req_valid = 1'b0;
  endtask
  // Response pulse stands in the cycle after the last access edge
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    req(1'b0, a, 8'h00);
    repeat (READ_CYC - 1) @(posedge core_clk);
    #1 chk(ADDR_W'(rsp_valid), ADDR_W'(1'b0));
    @(posedge core_clk);
    #1 chk(ADDR_W'(rsp_valid), ADDR_W'(1'b1));
    chk(ADDR_W'(rsp_rdata), ADDR_W'(exp));
  endtask
  task sc_rw_edges();
    req(1'b1, 19'h00000, 8'h3C);
    req(1'b1, 19'h7FFFF, 8'hC3);
    req(1'b1, 19'h00000, 8'h96);
    rd(19'h7FFFF, 8'hC3);
    rd(19'h00000, 8'h96);
    rd(19'h12345, 8'hBA);
  endtask
  // Refused request in retention, recovery length, contents kept
  task sc_retain();
    int n;
    n = 0;
    // Let the last read finish its float time first
    @(negedge core_clk);
    while (req_ready !== 1'b1) @(negedge core_clk);
    retain_req = 1'b1;
    req_valid = 1'b1;
    req_write = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(ADDR_W'({retain, cs_n, req_ready}), ADDR_W'(3'h6));
    req_valid = 1'b0;
    retain_req = 1'b0;
    @(negedge core_clk);
    while (req_ready !== 1'b1 && n < 50) begin
      n++;
      @(negedge core_clk);
    end
    chk(ADDR_W'(n), ADDR_W'(RECOV_CYC));
    rd(19'h00000, 8'h96);
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    chk(ADDR_W'({cs_n, oe_n, we_n, data_oe_n, req_ready}), ADDR_W'(5'h1F));
    sc_rw_edges();
    sc_retain();
    results();
  end
endmodule // sram_host_tb_top

// file: sram_pkg.sv
// Package for the asynchronous SRAM host controller: timing constants and states
package sram_pkg;

  // ----------------------------------------------------------------
  // Clock and geometry
  // ----------------------------------------------------------------
  // Core clock period in picoseconds (200 MHz)
  localparam int CLK_PERIOD_PS = 5000;
  // Address width for 512K words
  localparam int ADDR_W = 19;
  // Data width, one byte per word
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // Device timing, in ns as printed
  // ----------------------------------------------------------------
  localparam int READ_CYCLE_MIN_NS = 70;
  localparam int ADDR_ACCESS_MAX_NS = 70;
  localparam int SELECT_ACCESS_MAX_NS = 70;
  localparam int OE_ACCESS_MAX_NS = 35;
  localparam int DESELECT_TO_FLOAT_MAX_NS = 30;
  localparam int OE_OFF_TO_FLOAT_MAX_NS = 30;
  localparam int WRITE_CYCLE_MIN_NS = 70;
  localparam int SELECT_TO_WRITE_END_MIN_NS = 60;
  localparam int ADDR_TO_WRITE_END_MIN_NS = 60;
  localparam int WRITE_PULSE_MIN_NS = 50;
  localparam int WRITE_TO_FLOAT_MAX_NS = 30;
  localparam int DATA_SETUP_MIN_NS = 30;
  localparam int RETENTION_RECOVERY_MIN_NS = READ_CYCLE_MIN_NS;

  // ----------------------------------------------------------------
  // Cycle counts (least times round up, wait-for-max also rounds up)
  // ----------------------------------------------------------------
  localparam int READ_WAIT_NS = (ADDR_ACCESS_MAX_NS > SELECT_ACCESS_MAX_NS) ?
                                ADDR_ACCESS_MAX_NS : SELECT_ACCESS_MAX_NS;
  // Sample one cycle after the access time has passed
  localparam int READ_CYC = (READ_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
  // Bus float wait after read, before host may drive
  localparam int FLOAT_CYC = (OE_OFF_TO_FLOAT_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Write pulse with output enable held off: largest least time
  localparam int WP_NS_A = (WRITE_PULSE_MIN_NS > SELECT_TO_WRITE_END_MIN_NS) ?
                           WRITE_PULSE_MIN_NS : SELECT_TO_WRITE_END_MIN_NS;
  localparam int WP_NS = (WP_NS_A > ADDR_TO_WRITE_END_MIN_NS) ? WP_NS_A : ADDR_TO_WRITE_END_MIN_NS;
  // Data driven after write-to-float, then held for data setup
  localparam int WP_CONT_NS = DATA_SETUP_MIN_NS + WRITE_TO_FLOAT_MAX_NS;
  localparam int WP_CYC = (((WP_NS > WP_CONT_NS) ? WP_NS : WP_CONT_NS) * 1000 + CLK_PERIOD_PS - 1)
                          / CLK_PERIOD_PS;
  localparam int WC_CYC = (WRITE_CYCLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RECOV_CYC = (RETENTION_RECOVERY_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SR_IDLE,
    SR_READ,
    SR_FLOAT,
    SR_WRITE,
    SR_WREC,
    SR_RETAIN,
    SR_RECOVER
  } sram_state_t;

endpackage
